// *** rtl/sdf_consts.svh ***
// register offsets, field positions, reset values and limits of the filter
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_MODE        8'h00
`define OFS_DECIM       8'h04
`define OFS_STATUS      8'h08
`define OFS_DATA        8'h0c
`define OFS_OFFSET      8'h10
`define OFS_GAIN        8'h14

// ****************************************
// converter_mode_reg fields
// ****************************************
`define MODE_CAL_LSB    0
`define MODE_CAL_MSB    2
`define MODE_CHOP_OFF   3
`define MODE_ENABLE     4
`define MODE_NOTCH60    6

// ****************************************
// cal_mode_field codes
// ****************************************
`define CAL_IDLE        3'h0
`define CAL_CONT        3'h3
`define CAL_INT_ZERO    3'h4
`define CAL_INT_FULL    3'h5
`define CAL_SYS_ZERO    3'h6
`define CAL_SYS_FULL    3'h7

// ****************************************
// converter_status_reg fields
// ****************************************
`define STAT_DONE       0
`define STAT_REF_MISS   1
`define STAT_CAL_ERR    2

// ****************************************
// reset values and limits
// ****************************************
`define DECIM_RESET     8'h45
`define SF_MIN_CHOP     8'h0d
`define SF_MIN_NOCHOP   8'h03
`define GAIN_SHIFT      23

`endif

// *** rtl/sdf_pkg.sv ***
// types shared by the sigma-delta filter and its bus
package sdf_pkg;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CAL  = 3'b100
  } state_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// *** rtl/sigma_delta_filter_chop_calibration.sv ***
// sinc3 decimator with chop averaging, 60 hz notch and calibration
//
// What this block does
// - one-bit modulator stream in, multi-bit words out
// - decimation register sets filter output rate
// - mode bit 6 switches notch stage in
// - chopping swaps input polarity every output period
// - chop result averages new and previous words
// - mode bit 3 set disables chop and averaging
// - four calibration modes via calibration field
// - reset loads factory offset and gain coefficients
// - finished calibration overwrites loaded coefficients
// - zero-scale to offset, full-scale to gain
// - internal calibration routes own source to inputs
// - calibration runs at current decimation rate
// - subtract offset first, then multiply by gain
// - done flag set at end of calibration
// - reference-missing flag raised during conversion
// - missing reference aborts calibration, no coefficient write
// - codes 100 and 101 start internal calibrations
// - internal full-scale uses reference at unity gain
// - codes 110 and 111 start system calibrations
// - chop on: factor below 13 acts as 13
// - chop off: smallest factor is 3
// - missing reference during calibration sets calibration error flag
`timescale 1ns/10ps
`include "sdf_consts.svh"

module sigma_delta_filter_chop_calibration
  import sdf_pkg::*;
#(
  parameter logic [23:0] FACTORY_OFFSET = 24'h000000,
  parameter logic [23:0] FACTORY_GAIN   = 24'h800000
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // analog side pins
  input  wire logic        mod_bit_i,
  input  wire logic        ref_ok_i,
  // register bus
  input  wire apb_req_t    apb_i,
  output      apb_rsp_t    apb_o,
  // input routing towards the modulator
  output      logic        chop_swap_o,
  output      logic        cal_zero_o,
  output      logic        cal_full_o,
  output      logic        cal_unity_gain_o,
  // corrected result stream
  output      logic [23:0] result_o,
  output      logic        result_valid_o
);

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic               mod_s1;
    logic               mod_s2;
    logic               ref_s1;
    logic               ref_s2;
    state_t             state;
    logic [2:0]         cal_mode;
    logic               chop_off;
    logic               enable;
    logic               notch60_enable;
    logic [7:0]         decim;
    logic [7:0]         cnt;
    logic signed [24:0] int1;
    logic signed [24:0] int2;
    logic signed [24:0] int3;
    logic signed [24:0] dly1;
    logic signed [24:0] dly2;
    logic signed [24:0] dly3;
    logic signed [24:0] prev_notch;
    logic signed [24:0] prev_word;
    logic [1:0]         fresh;
    logic               swap;
    logic [23:0]        offset;
    logic [23:0]        gain;
    logic [23:0]        data;
    logic               done;
    logic               ref_miss;
    logic               cal_err;
    logic               cal_zero;
    logic               cal_full;
    logic               out_vld;
    apb_rsp_t           rsp;
  } regs_t;

  regs_t q, d;

  // ****************************************
  // address decode, shared by read and write
  // ****************************************
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    if (a == `OFS_MODE) begin
      reg_index = 3'h1;
    end else if (a == `OFS_DECIM) begin
      reg_index = 3'h2;
    end else if (a == `OFS_STATUS) begin
      reg_index = 3'h3;
    end else if (a == `OFS_DATA) begin
      reg_index = 3'h4;
    end else if (a == `OFS_OFFSET) begin
      reg_index = 3'h5;
    end else if (a == `OFS_GAIN) begin
      reg_index = 3'h6;
    end else begin
      reg_index = 3'h0;
    end
  endfunction

  // combinational helpers
  logic               access;
  logic               wr_take;
  logic [2:0]         idx;
  logic [7:0]         eff_sf;
  logic               dump;
  logic signed [24:0] x_in;
  logic signed [24:0] c1;
  logic signed [24:0] c2;
  logic signed [24:0] c3;
  logic signed [24:0] w_pol;
  logic signed [24:0] w_notch;
  logic signed [24:0] w_avg;
  logic               w_valid;
  logic signed [25:0] w_diff;
  logic signed [50:0] prod;
  logic [23:0]        corr;
  logic [2:0]         new_mode;

  always_comb begin
    d        = q;
    access   = apb_i.psel & apb_i.penable;
    wr_take  = access & q.rsp.pready & apb_i.pwrite;
    idx      = reg_index(apb_i.paddr);
    eff_sf   = 8'h00;
    dump     = 1'b0;
    x_in     = 25'sd0;
    c1       = 25'sd0;
    c2       = 25'sd0;
    c3       = 25'sd0;
    w_pol    = 25'sd0;
    w_notch  = 25'sd0;
    w_avg    = 25'sd0;
    w_valid  = 1'b0;
    w_diff   = 26'sd0;
    prod     = 51'sd0;
    corr     = 24'h000000;
    new_mode = apb_i.pwdata[`MODE_CAL_MSB:`MODE_CAL_LSB];

    // pins cross into the clock domain through two flops
    d.mod_s1 = mod_bit_i;
    d.mod_s2 = q.mod_s1;
    d.ref_s1 = ref_ok_i;
    d.ref_s2 = q.ref_s1;
    d.out_vld = 1'b0;

    // ****************************************
    // apb slave: answer one cycle into access
    // ****************************************
    d.rsp.pready = access & ~q.rsp.pready;
    if (access && !q.rsp.pready) begin
      d.rsp.pslverr = (idx == 3'h0);
      d.rsp.prdata  = 32'h00000000;
      if (idx == 3'h1) begin
        d.rsp.prdata[`MODE_CAL_MSB:`MODE_CAL_LSB] = q.cal_mode;
        d.rsp.prdata[`MODE_CHOP_OFF] = q.chop_off;
        d.rsp.prdata[`MODE_ENABLE]   = q.enable;
        d.rsp.prdata[`MODE_NOTCH60]  = q.notch60_enable;
      end else if (idx == 3'h2) begin
        d.rsp.prdata[7:0] = q.decim;
      end else if (idx == 3'h3) begin
        d.rsp.prdata[`STAT_DONE]     = q.done;
        d.rsp.prdata[`STAT_REF_MISS] = q.ref_miss;
        d.rsp.prdata[`STAT_CAL_ERR]  = q.cal_err;
      end else if (idx == 3'h4) begin
        d.rsp.prdata[23:0] = q.data;
      end else if (idx == 3'h5) begin
        d.rsp.prdata[23:0] = q.offset;
      end else if (idx == 3'h6) begin
        d.rsp.prdata[23:0] = q.gain;
      end
    end else begin
      // answer lasts one cycle, so a stale error never lingers
      d.rsp.pslverr = 1'b0;
      d.rsp.prdata  = 32'h00000000;
    end

    // ****************************************
    // register writes, taken at the ready edge
    // ****************************************
    if (wr_take) begin
      if (idx == 3'h1) begin
        d.chop_off       = apb_i.pwdata[`MODE_CHOP_OFF];
        d.enable         = apb_i.pwdata[`MODE_ENABLE];
        d.notch60_enable = apb_i.pwdata[`MODE_NOTCH60];
        d.cal_mode       = new_mode;
        // every mode write restarts the count, chop phase and first-output drop; integrators and comb delays keep their values
        d.fresh = 2'd0;
        d.cnt   = 8'h00;
        d.swap  = 1'b0;
        d.cal_zero = 1'b0;
        d.cal_full = 1'b0;
        if (!apb_i.pwdata[`MODE_ENABLE] || new_mode == `CAL_IDLE) begin
          d.state    = ST_IDLE;
          d.cal_mode = `CAL_IDLE;
        end else if (new_mode[2]) begin
          // calibrations only start on an enabled converter
          d.state    = ST_CAL;
          d.cal_zero = (new_mode == `CAL_INT_ZERO);
          d.cal_full = (new_mode == `CAL_INT_FULL);
        end else begin
          d.state = ST_CONV;
        end
      end else if (idx == 3'h2) begin
        d.decim = apb_i.pwdata[7:0];
      end else if (idx == 3'h3) begin
        // write one to clear; hardware sets below win
        if (apb_i.pwdata[`STAT_DONE]) begin
          d.done = 1'b0;
        end
        if (apb_i.pwdata[`STAT_CAL_ERR]) begin
          d.cal_err = 1'b0;
        end
      end else if (idx == 3'h5) begin
        d.offset = apb_i.pwdata[23:0];
      end else if (idx == 3'h6) begin
        d.gain = apb_i.pwdata[23:0];
      end
    end

    // ****************************************
    // effective decimation factor
    // ****************************************
    if (!q.chop_off && q.decim < `SF_MIN_CHOP) begin
      eff_sf = `SF_MIN_CHOP;
    end else if (q.chop_off && q.decim < `SF_MIN_NOCHOP) begin
      eff_sf = `SF_MIN_NOCHOP;
    end else begin
      eff_sf = q.decim;
    end

    // ****************************************
    // sinc3 decimator, bipolar one-bit input
    // ****************************************
    x_in = q.mod_s2 ? 25'sd1 : -25'sd1;
    if (q.state != ST_IDLE && !wr_take) begin
      d.int1 = q.int1 + x_in;
      d.int2 = q.int2 + q.int1;
      d.int3 = q.int3 + q.int2;
      dump   = (q.cnt >= eff_sf - 8'h01);
      d.cnt  = dump ? 8'h00 : q.cnt + 8'h01;
    end

    // comb section at the decimated rate
    if (dump) begin
      c1 = q.int3 - q.dly1;
      c2 = c1 - q.dly2;
      c3 = c2 - q.dly3;
      d.dly1 = q.int3;
      d.dly2 = c1;
      d.dly3 = c2;
      // undo the input swap of the period just closed
      w_pol = q.swap ? -c3 : c3;
      // two-tap notch stage, bypassed when disabled
      w_notch = q.notch60_enable ? ((w_pol + q.prev_notch) >>> 1) : w_pol;
      d.prev_notch = w_pol;
      if (q.chop_off) begin
        w_avg   = w_notch;
        w_valid = 1'b1;
        d.swap  = 1'b0;
      end else begin
        w_avg   = (w_notch + q.prev_word) >>> 1;
        w_valid = (q.fresh != 2'd0);
        d.swap  = ~q.swap;
      end
      d.prev_word = w_notch;
      if (q.fresh != 2'd2) begin
        d.fresh = q.fresh + 2'd1;
      end
    end

    // offset subtract, then gain multiply
    w_diff = {w_avg[24], w_avg} - {{2{q.offset[23]}}, q.offset};
    prod   = w_diff * $signed({1'b0, q.gain});
    if (prod[50:46] != {5{prod[46]}}) begin
      corr = prod[50] ? 24'h800000 : 24'h7fffff;
    end else begin
      corr = prod[`GAIN_SHIFT+23:`GAIN_SHIFT];
    end

    // ****************************************
    // reference watch and result hand-off
    // ****************************************
    d.ref_miss = ~q.ref_s2 & (q.state != ST_IDLE);
    if (q.state == ST_CAL && !q.ref_s2 && !wr_take) begin
      // halt at once, coefficients stay as they were
      d.cal_err  = 1'b1;
      d.state    = ST_IDLE;
      d.cal_mode = `CAL_IDLE;
      d.cal_zero = 1'b0;
      d.cal_full = 1'b0;
    end else if (dump && w_valid && q.state == ST_CAL) begin
      if (q.cal_mode[0]) begin
        d.gain = w_avg[24:1];
      end else begin
        d.offset = w_avg[24:1];
      end
      d.done     = 1'b1;
      d.state    = ST_IDLE;
      d.cal_mode = `CAL_IDLE;
      d.cal_zero = 1'b0;
      d.cal_full = 1'b0;
    end else if (dump && w_valid && q.state == ST_CONV) begin
      // clamp results while the reference is gone
      d.data    = q.ref_s2 ? corr : 24'h7fffff;
      d.done    = 1'b1;
      d.out_vld = 1'b1;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q                <= '0;
      q.state          <= ST_IDLE;
      q.decim          <= `DECIM_RESET;
      q.ref_s1         <= 1'b1;
      q.ref_s2         <= 1'b1;
      q.offset         <= FACTORY_OFFSET;
      q.gain           <= FACTORY_GAIN;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state record
  assign apb_o            = q.rsp;
  assign chop_swap_o      = q.swap;
  assign cal_zero_o       = q.cal_zero;
  assign cal_full_o       = q.cal_full;
  assign cal_unity_gain_o = q.cal_full;
  assign result_o         = q.data;
  assign result_valid_o   = q.out_vld;

endmodule // sigma_delta_filter_chop_calibration

// *** tb/sdf_mod_model.sv ***
// behavioural modulator and input routing that face the filter
`timescale 1ns/10ps

module sdf_mod_model (
  // clock
  input  wire logic clk_i,
  // routing requests from the filter
  input  wire logic swap_i,
  input  wire logic zero_i,
  input  wire logic full_i,
  // comparator stream
  output logic      bit_o
);
  logic [1:0] ph_q = 2'h0;
  logic       raw;

  // ****************************************
  // stream source
  // ****************************************
  // routed sources win over the pins; the pins carry 3/4 ones, the level
  // the bench applies before any system calibration starts
  always_comb begin
    if (full_i) begin
      raw = 1'b1;
    end else if (zero_i) begin
      raw = ph_q[0];
    end else begin
      raw = (ph_q != 2'h0);
    end
  end

  // swapped inputs invert the comparator sense
  always @(posedge clk_i) begin
    ph_q  <= ph_q + 2'h1;
    bit_o <= raw ^ swap_i;
  end
endmodule // sdf_mod_model

// *** tb/sdf_props.sv ***
// assertions watching the filter's ports
`timescale 1ns/10ps
`include "sdf_consts.svh"

module sdf_chk
  import sdf_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // analog side
  input wire logic        mod_bit_i,
  input wire logic        ref_ok_i,
  // bus
  input wire apb_req_t    apb_i,
  input wire apb_rsp_t    apb_o,
  // routing and result
  input wire logic        chop_swap_o,
  input wire logic        cal_zero_o,
  input wire logic        cal_full_o,
  input wire logic        cal_unity_gain_o,
  input wire logic [23:0] result_o,
  input wire logic        result_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_mode;
  // ****************************************
  // helpers
  // ****************************************
  assign wr_mode = apb_i.psel && apb_i.penable && apb_o.pready
                   && apb_i.pwrite && apb_i.paddr == `OFS_MODE
                   && apb_i.pwdata[4] && ref_ok_i;

  // ****************************************
  // assertions
  // ****************************************
  AST_UNITY: assert property (cal_unity_gain_o == cal_full_o)
    else $error("unity gain not tied to full-scale routing");
  AST_ONE_SRC: assert property (!(cal_zero_o && cal_full_o))
    else $error("both calibration sources routed");
  AST_READY: assert property (apb_o.pready |-> apb_i.psel
    && apb_i.penable && $past(apb_i.penable))
    else $error("pready outside second access cycle");
  AST_SLVERR: assert property (apb_o.pslverr |-> apb_o.pready
    && apb_o.prdata == 32'h0)
    else $error("error answer malformed");
  AST_GAP: assert property (result_valid_o |=> !result_valid_o[*2])
    else $error("results closer than three cycles");
  AST_ABORT: assert property ($fell(ref_ok_i) && cal_zero_o
    |-> ##[1:4] !cal_zero_o)
    else $error("calibration not halted on lost reference");
  AST_INT_ZERO: assert property (wr_mode && apb_i.pwdata[2:0] == 3'h4
    |-> ##[1:3] cal_zero_o)
    else $error("zero-scale source not routed");
  AST_INT_FULL: assert property (wr_mode && apb_i.pwdata[2:0] == 3'h5
    |-> ##[1:3] cal_full_o)
    else $error("full-scale source not routed");
  AST_RST_OUT: assert property ($fell(rst_i) |-> !cal_zero_o
    && !cal_full_o && !result_valid_o && !apb_o.pready)
    else $error("outputs active straight after reset");
  C_ZERO: cover property (cal_zero_o ##1 !cal_zero_o);
  C_FULL: cover property (cal_full_o ##1 !cal_full_o);
  C_VALID: cover property (result_valid_o && !chop_swap_o);
endmodule // sdf_chk

bind sigma_delta_filter_chop_calibration sdf_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .mod_bit_i(mod_bit_i), .ref_ok_i(ref_ok_i),
  .apb_i(apb_i), .apb_o(apb_o), .chop_swap_o(chop_swap_o),
  .cal_zero_o(cal_zero_o), .cal_full_o(cal_full_o),
  .cal_unity_gain_o(cal_unity_gain_o), .result_o(result_o),
  .result_valid_o(result_valid_o));

// *** tb/sigma_delta_filter_chop_calibration_test.sv ***
// self-checking bench of the sigma-delta filter
`timescale 1ns/10ps
`include "sdf_consts.svh"

module sigma_delta_filter_chop_calibration_test;
  import sdf_pkg::*;
  localparam logic [31:0] F_OFS = 32'h000abcde;
  localparam logic [31:0] F_GN  = 32'h00800000;
  typedef struct packed {
    logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;
  } row_t;
  typedef struct packed { logic [31:0] m, sf, gap, tog; } gap_t;
  logic clk_i = 1'b0, rst_i = 1'b1, ref_ok_i = 1'b1, mod_bit_i;
  logic chop_swap_o, cal_zero_o, cal_full_o, result_valid_o;
  logic cal_unity_gain_o;
  logic [23:0] result_o;
  apb_req_t apb_i = '0;
  apb_rsp_t apb_o;
  int miscompares = 0, compares = 0, cyc = 0;
  logic [31:0] q, o_prev, g_prev;
  logic e;
  row_t rows[9] = '{'{0, `OFS_DECIM, 0, 32'h45, 0},
    '{0, `OFS_OFFSET, 0, F_OFS, 0}, '{0, `OFS_GAIN, 0, F_GN, 0},
    '{0, `OFS_STATUS, 0, 0, 0}, '{0, `OFS_MODE, 0, 0, 0},
    '{1, `OFS_DECIM, 32'h1ff, 0, 0}, '{0, `OFS_DECIM, 0, 32'hff, 0},
    '{0, 8'h18, 0, 0, 1}, '{1, 8'h1c, 32'h5, 0, 1}};
  // the notch row keeps the factor at 68 or above
  gap_t gaps[5] = '{'{32'h1b, 3, 3, 0}, '{32'h13, 5, 13, 1},
    '{32'h13, 20, 20, 1}, '{32'h53, 68, 68, 1}, '{32'h1b, 7, 7, 0}};

  // ****************************************
  // clock, parts and timeout
  // ****************************************
  always #5 clk_i = ~clk_i;
  sigma_delta_filter_chop_calibration #(.FACTORY_OFFSET(F_OFS[23:0]),
    .FACTORY_GAIN(F_GN[23:0])) dut (.clk_i(clk_i), .rst_i(rst_i),
    .mod_bit_i(mod_bit_i), .ref_ok_i(ref_ok_i), .apb_i(apb_i), .apb_o(apb_o),
    .chop_swap_o(chop_swap_o), .cal_zero_o(cal_zero_o),
    .cal_full_o(cal_full_o), .cal_unity_gain_o(cal_unity_gain_o),
    .result_o(result_o),
    .result_valid_o(result_valid_o));
  sdf_mod_model u_mod (.clk_i(clk_i), .swap_i(chop_swap_o),
    .zero_i(cal_zero_o), .full_i(cal_full_o), .bit_o(mod_bit_i));
  // a hang ends the run through the normal report
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 50);
    q = apb_o.prdata;
    e = apb_o.pslverr;
    if (n >= 50) miscompares++;
    apb_i <= '0;
  endtask
  task automatic wait_valid(output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (result_valid_o !== 1'b1 && n < 600);
    if (n >= 600) miscompares++;
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n, t;
    logic s;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(q, rows[i].q);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    $display("test registers done");
    // rate and swap count over one output period
    foreach (gaps[i]) begin
      apb(1'b1, `OFS_DECIM, gaps[i].sf);
      apb(1'b1, `OFS_MODE, gaps[i].m);
      wait_valid(n);
      // chop drops the first output; the second one is the first result
      chk(n, (gaps[i].tog + 1) * gaps[i].gap + 1);
      t = 0;
      n = 0;
      s = chop_swap_o;
      do begin
        @(negedge clk_i);
        n++;
        if (chop_swap_o !== s) t++;
        s = chop_swap_o;
      end while (result_valid_o !== 1'b1 && n < 600);
      chk(n, gaps[i].gap);
      chk(t, gaps[i].tog);
    end
    $display("test rates done");
    // zero gain forces a zero result; lost reference clamps it
    apb(1'b1, `OFS_GAIN, 32'h0);
    repeat (2) wait_valid(n);
    chk(result_o, 24'h0);
    apb(1'b1, `OFS_GAIN, F_GN);
    ref_ok_i <= 1'b0;
    repeat (2) wait_valid(n);
    chk(result_o, 24'h7fffff);
    apb(1'b0, `OFS_STATUS, 0);
    chk(q[1], 1'b1);
    ref_ok_i <= 1'b1;
    apb(1'b1, `OFS_MODE, 32'h0);
    apb(1'b1, `OFS_STATUS, 32'h7);
    $display("test correction done");
    // the four calibration codes, chop off, zero before full
    for (int c = 4; c < 8; c++) begin
      apb(1'b0, `OFS_OFFSET, 0);
      o_prev = q;
      apb(1'b0, `OFS_GAIN, 0);
      g_prev = q;
      apb(1'b1, `OFS_MODE, 32'h18 | c);
      repeat (2) @(negedge clk_i);
      chk({cal_zero_o, cal_full_o}, {c == 4, c == 5});
      chk(cal_unity_gain_o, c == 5);
      // internal runs close one output period (factor 7) after the write
      n = 2;
      while ((cal_zero_o || cal_full_o) && n < 600) begin
        @(negedge clk_i);
        n++;
      end
      if (c < 6) chk(n, 8);
      n = 0;
      do begin
        apb(1'b0, `OFS_STATUS, 0);
        n++;
      end while (q[0] !== 1'b1 && n < 100);
      chk(q[2:0], 3'h1);
      apb(1'b1, `OFS_STATUS, 32'h1);
      apb(1'b0, `OFS_STATUS, 0);
      chk(q[0], 1'b0);
      apb(1'b0, `OFS_MODE, 0);
      chk(q[2:0], 3'h0);
      apb(1'b0, `OFS_OFFSET, 0);
      chk(q != o_prev, !c[0]);
      apb(1'b0, `OFS_GAIN, 0);
      chk(q != g_prev, c[0]);
    end
    $display("test calibration done");
    // reference lost in mid calibration
    apb(1'b0, `OFS_OFFSET, 0);
    o_prev = q;
    apb(1'b1, `OFS_DECIM, 32'h28);
    apb(1'b1, `OFS_MODE, 32'h1c);
    repeat (3) @(posedge clk_i);
    ref_ok_i <= 1'b0;
    repeat (10) @(negedge clk_i);
    chk(cal_zero_o, 1'b0);
    apb(1'b0, `OFS_STATUS, 0);
    chk({q[2], q[0]}, 2'h2);
    apb(1'b0, `OFS_OFFSET, 0);
    chk(q, o_prev);
    ref_ok_i <= 1'b1;
    $display("test abort done");
    // reset in mid conversion reloads the factory coefficients
    apb(1'b1, `OFS_MODE, 32'h1b);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, `OFS_OFFSET, 0);
    chk(q, F_OFS);
    apb(1'b0, `OFS_GAIN, 0);
    chk(q, F_GN);
    $display("test reset done");
    finish_test();
  end
endmodule // sigma_delta_filter_chop_calibration_test
